// *** logic/epiu_defs.svh ***
`ifndef EPIU_DEFS_SVH
`define EPIU_DEFS_SVH

// register byte addresses; each register is one byte in lane 0 of its own address
`define EPIU_IDX_ENABLE 8'h3d
`define EPIU_IDX_SENSE 8'h69
`define EPIU_IDX_FLAGS 8'h3c
`define EPIU_IDX_GRP_ENABLE 8'h68
`define EPIU_IDX_GRP_FLAGS 8'h3b
`define EPIU_IDX_MASK0 8'h6b
`define EPIU_IDX_MASK1 8'h6c
`define EPIU_IDX_MASK2 8'h6d
`define EPIU_IDX_STATUS 8'h70

// field layout
`define EPIU_SENSE_PIN1_HI 3
`define EPIU_SENSE_PIN1_LO 2
`define EPIU_SENSE_PIN0_HI 1
`define EPIU_SENSE_PIN0_LO 0
`define EPIU_SENSE_USED 8'h0f
`define EPIU_ENABLE_USED 8'h03
`define EPIU_GRP_USED 8'h07
`define EPIU_MASK1_USED 8'h7f

// reset values
`define EPIU_RST_REG 8'h00

`endif

// *** logic/epiu_pkg.sv ***
package epiu_pkg;
   typedef enum logic [1:0] {
      epiu_sense_low,
      epiu_sense_any,
      epiu_sense_fall,
      epiu_sense_rise
   } epiu_sense_e;

   typedef enum logic [1:0] {
      epiu_bus_idle,
      epiu_bus_ack
   } epiu_bus_e;
endpackage

// *** logic/epiu_pin_sense.sv ***
`timescale 1ns/1ps
// one dedicated request pin: sampled for edge decode, level decoded straight from the pin
module epiu_pin_sense
   import epiu_pkg::*;
(
   // clock
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic clk_en,
   // pin and mode
   input wire logic pin_in,
   input wire logic [1:0] sense_sel,
   // result
   output logic edge_hit,
   output logic level_hit
);
   typedef struct packed {
      logic sampled;
      logic prev;
   } epiu_pin_s;

   epiu_pin_s st;
   epiu_pin_s next_st;
   epiu_sense_e mode;

   assign mode = epiu_sense_e'(sense_sel);

   always_comb begin
      next_st = st;
      next_st.sampled = pin_in;
      next_st.prev = st.sampled;
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         st <= '0;
      end else if (clk_en) begin
         st <= next_st;
      end
   end

   // level bypasses the sampler so it holds even with the clock stopped
   assign level_hit = (mode == epiu_sense_low) && !pin_in;
   always_comb begin
      unique case (mode)
         epiu_sense_low: edge_hit = 1'b0;
         epiu_sense_any: edge_hit = st.sampled ^ st.prev;
         epiu_sense_fall: edge_hit = st.prev && !st.sampled;
         epiu_sense_rise: edge_hit = !st.prev && st.sampled;
      endcase
   end
endmodule

// *** logic/epiu_change_group.sv ***
`timescale 1ns/1ps
// one pin-change group: masked inputs, change against last seen value
module epiu_change_group
   import epiu_pkg::*;
(
   // clock
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic clk_en,
   // inputs
   input wire logic [7:0] pins,
   input wire logic [7:0] mask,
   input wire logic grp_enable,
   // result
   output logic change_async,
   output logic change_hit
);
   typedef struct packed {
      logic [7:0] last;
   } epiu_grp_s;

   epiu_grp_s st;
   epiu_grp_s next_st;
   logic [7:0] armed;

   assign armed = mask & {8{grp_enable}};

   always_comb begin
      next_st = st;
      next_st.last = pins;
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         st <= '0;
      end else if (clk_en) begin
         st <= next_st;
      end
   end

   // combinational compare gives a wake term without any clock edge
   assign change_async = |((pins ^ st.last) & armed);
   assign change_hit = change_async;
endmodule

// *** logic/epiu_top.sv ***
`timescale 1ns/1ps
`include "epiu_defs.svh"
// Contract
// - pin requests raise even when the pin is driven as output.
// - group 2 from inputs 23..16, group 1 from 14..8, group 0 from 7..0.
// - three mask registers pick the inputs that feed each group.
// - pin-change detection works without a clock, for wake-up.
// - sense code 00 low, 01 any change, 10 fall, 11 rise; pin1 bits 3:2.
// - level mode keeps requesting while the pin stays low.
// - edges are seen only while the clock runs.
// - low level is detected without a clock.
// - a wake level must outlast start-up or no request results.
// - pins are sampled before edge detection; one-period pulses caught.
// - pin request goes to core only with global and pin enable set.
// - each dedicated pin has its own request line.
// - an edge or change sets the pin flag and requests the vector.
// - pin flag clears on vector entry or on written one.
// - pin flag stays zero while the pin is in level mode.
// - unused upper bits of sense, enable and flag registers read zero.
// - group request needs group enable and global enable.
// - group flag sets on change, clears on vector entry or written one.
// - an input counts only with its mask bit and group enable set.
module epiu_top
   import epiu_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic clk_en,
   // avalon-mm slave
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // pins
   input wire logic ext_req_pin_zero,
   input wire logic ext_req_pin_one,
   input wire logic [23:0] pin_change_inputs,
   // core side
   input wire logic global_irq_enable,
   input wire logic [1:0] ext_vector_ack,
   input wire logic [2:0] group_vector_ack,
   output logic [1:0] ext_vector_req,
   output logic [2:0] group_vector_req,
   output logic wake_req
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      epiu_bus_e bus;
      logic [31:0] rdata;
      logic [7:0] enable;
      logic [7:0] sense;
      logic [1:0] ext_flag;
      logic [7:0] grp_enable;
      logic [2:0] grp_flag;
      logic [7:0] mask0;
      logic [7:0] mask1;
      logic [7:0] mask2;
   } epiu_top_s;

   epiu_top_s st;
   epiu_top_s next_st;

   logic [1:0] edge_hit;
   logic [1:0] level_hit;
   logic [2:0] grp_async;
   logic [2:0] grp_hit;
   logic [23:0] grp_pins;
   logic wr_fire;
   logic rd_fire;
   logic [7:0] wbyte;

   // ------------------------------------------------------------
   // detectors
   // ------------------------------------------------------------
   // pins feed straight in, whatever their port direction is
   epiu_pin_sense u_pin0 (
      .clk_sys(clk_sys),
      .srst(srst),
      .clk_en(clk_en),
      .pin_in(ext_req_pin_zero),
      .sense_sel(st.sense[`EPIU_SENSE_PIN0_HI:`EPIU_SENSE_PIN0_LO]),
      .edge_hit(edge_hit[0]),
      .level_hit(level_hit[0])
   );

   epiu_pin_sense u_pin1 (
      .clk_sys(clk_sys),
      .srst(srst),
      .clk_en(clk_en),
      .pin_in(ext_req_pin_one),
      .sense_sel(st.sense[`EPIU_SENSE_PIN1_HI:`EPIU_SENSE_PIN1_LO]),
      .edge_hit(edge_hit[1]),
      .level_hit(level_hit[1])
   );

   // input 15 has no mask bit, so it never reaches group 1
   assign grp_pins = {pin_change_inputs[23:16], 1'b0, pin_change_inputs[14:0]};

   epiu_change_group u_grp0 (
      .clk_sys(clk_sys),
      .srst(srst),
      .clk_en(clk_en),
      .pins(grp_pins[7:0]),
      .mask(st.mask0),
      .grp_enable(st.grp_enable[0]),
      .change_async(grp_async[0]),
      .change_hit(grp_hit[0])
   );

   epiu_change_group u_grp1 (
      .clk_sys(clk_sys),
      .srst(srst),
      .clk_en(clk_en),
      .pins(grp_pins[15:8]),
      .mask(st.mask1 & `EPIU_MASK1_USED),
      .grp_enable(st.grp_enable[1]),
      .change_async(grp_async[1]),
      .change_hit(grp_hit[1])
   );

   epiu_change_group u_grp2 (
      .clk_sys(clk_sys),
      .srst(srst),
      .clk_en(clk_en),
      .pins(grp_pins[23:16]),
      .mask(st.mask2),
      .grp_enable(st.grp_enable[2]),
      .change_async(grp_async[2]),
      .change_hit(grp_hit[2])
   );

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   function automatic logic [7:0] read_reg(input logic [7:0] addr, input epiu_top_s s);
      logic [7:0] v;
      v = 8'h00;
      unique case (addr)
         `EPIU_IDX_ENABLE: v = s.enable & `EPIU_ENABLE_USED;
         `EPIU_IDX_SENSE: v = s.sense & `EPIU_SENSE_USED;
         `EPIU_IDX_FLAGS: v = {6'h00, s.ext_flag};
         `EPIU_IDX_GRP_ENABLE: v = s.grp_enable & `EPIU_GRP_USED;
         `EPIU_IDX_GRP_FLAGS: v = {5'h00, s.grp_flag};
         `EPIU_IDX_MASK0: v = s.mask0;
         `EPIU_IDX_MASK1: v = s.mask1 & `EPIU_MASK1_USED;
         `EPIU_IDX_MASK2: v = s.mask2;
         `EPIU_IDX_STATUS: v = {2'h0, level_hit, 1'b0, grp_async};
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   // one wait cycle per access; read data is registered in the wait cycle,
   // a write lands only at the edge that ends the request, as the master expects
   assign rd_fire = avs_read && (st.bus == epiu_bus_idle);
   assign wr_fire = avs_write && (st.bus == epiu_bus_ack) && avs_byteenable[0];
   assign wbyte = avs_writedata[7:0];
   assign avs_waitrequest = (avs_read || avs_write) && (st.bus == epiu_bus_idle);
   assign avs_readdata = st.rdata;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.bus = epiu_bus_idle;
      if ((avs_read || avs_write) && st.bus == epiu_bus_idle) begin
         next_st.bus = epiu_bus_ack;
      end
      if (rd_fire) begin
         next_st.rdata = {24'h000000, read_reg(avs_address, st)};
      end
      if (wr_fire) begin
         unique case (avs_address)
            `EPIU_IDX_ENABLE: next_st.enable = wbyte & `EPIU_ENABLE_USED;
            `EPIU_IDX_SENSE: next_st.sense = wbyte & `EPIU_SENSE_USED;
            `EPIU_IDX_GRP_ENABLE: next_st.grp_enable = wbyte & `EPIU_GRP_USED;
            `EPIU_IDX_MASK0: next_st.mask0 = wbyte;
            `EPIU_IDX_MASK1: next_st.mask1 = wbyte & `EPIU_MASK1_USED;
            `EPIU_IDX_MASK2: next_st.mask2 = wbyte;
            default: next_st.rdata = st.rdata;
         endcase
      end
      // clears first, then sets, so a same-cycle event wins
      if (wr_fire && avs_address == `EPIU_IDX_FLAGS) begin
         next_st.ext_flag = st.ext_flag & ~wbyte[1:0];
      end
      if (wr_fire && avs_address == `EPIU_IDX_GRP_FLAGS) begin
         next_st.grp_flag = st.grp_flag & ~wbyte[2:0];
      end
      next_st.ext_flag = next_st.ext_flag & ~ext_vector_ack;
      next_st.grp_flag = next_st.grp_flag & ~group_vector_ack;
      next_st.ext_flag = next_st.ext_flag | edge_hit;
      next_st.grp_flag = next_st.grp_flag | grp_hit;
      for (int i = 0; i < 2; i++) begin
         if (st.sense[2*i +: 2] == 2'b00) begin
            next_st.ext_flag[i] = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         st <= '0;
      end else if (clk_en) begin
         st <= next_st;
      end
   end

   // ------------------------------------------------------------
   // requests to the core
   // ------------------------------------------------------------
   // a level request vanishing before the core looks simply leaves no request
   assign ext_vector_req = (st.ext_flag | level_hit) & st.enable[1:0]
      & {2{global_irq_enable}};
   assign group_vector_req = st.grp_flag & st.grp_enable[2:0]
      & {3{global_irq_enable}};
   // wake ignores the global enable and any clock
   assign wake_req = |(level_hit & st.enable[1:0]) || (|grp_async);
endmodule

// *** testbench/epiu_top_chk.sv ***
`timescale 1ns/1ps
module epiu_top_chk (
   // clock
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic clk_en,
   // bus
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // pins and core
   input wire logic [23:0] pin_change_inputs,
   input wire logic global_irq_enable,
   input wire logic [2:0] group_vector_ack,
   input wire logic [1:0] ext_vector_req,
   input wire logic [2:0] group_vector_req
);
   default clocking dc @(posedge clk_sys);
   endclocking
   default disable iff (srst);
   logic rd_done;
   assign rd_done = avs_read && !avs_waitrequest;
   a_one_wait: assert property (
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("late answer");
   a_upper_zero: assert property (
      rd_done |-> avs_readdata[31:8] == 24'h0) else $error("upper read bits set");
   a_unmapped_zero: assert property (
      rd_done && avs_address == 8'h00 |-> avs_readdata == 32'h0) else $error("unmapped read");
   a_sense_unused: assert property (
      rd_done && avs_address == 8'h69 |-> avs_readdata[7:4] == 4'h0) else $error("sense upper");
   a_enable_unused: assert property (
      rd_done && (avs_address == 8'h3d || avs_address == 8'h3c) |-> avs_readdata[7:2] == 6'h0)
      else $error("enable or flag upper bits set");
   a_pin_needs_gie: assert property (
      ext_vector_req != 2'b00 |-> global_irq_enable) else $error("pin request without enable");
   a_grp_needs_gie: assert property (
      group_vector_req != 3'b000 |-> global_irq_enable) else $error("group request ungated");
   // a fresh change in the same cycle may set the flag again, so inputs must stand still
   a_grp_ack_clr: assert property (
      clk_en && $past(clk_en) && group_vector_ack[0] && $stable(pin_change_inputs[7:0])
      |=> !group_vector_req[0]) else $error("group ack did not clear");
endmodule

bind epiu_top epiu_top_chk u_chk (.clk_sys(clk_sys), .srst(srst), .clk_en(clk_en),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .pin_change_inputs(pin_change_inputs), .global_irq_enable(global_irq_enable),
   .group_vector_ack(group_vector_ack), .ext_vector_req(ext_vector_req),
   .group_vector_req(group_vector_req));

// *** testbench/epiu_pin_src.sv ***
`timescale 1ns/1ps
module epiu_pin_src (
   // clock
   input wire logic clk_sys,
   // levels asked for by the bench
   input wire logic [25:0] want,
   // pins
   output logic ext_req_pin_zero,
   output logic ext_req_pin_one,
   output logic [23:0] pin_change_inputs
);
   initial {ext_req_pin_one, ext_req_pin_zero, pin_change_inputs} = 26'h3000000;
   // each level is held until asked otherwise, so a low level outlasts any instruction
   always @(posedge clk_sys) begin
      {ext_req_pin_one, ext_req_pin_zero, pin_change_inputs} <= want;
   end
endmodule

// *** testbench/tb.sv ***
`timescale 1ns/1ps
module tb;
   logic clk_sys = 1'b0, srst = 1'b1, clk_en = 1'b1, gie = 1'b0;
   logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest, pin0, pin1, wake, e;
   logic [7:0] avs_address = 8'h00, msk;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
   logic [3:0] be = 4'h1;
   logic [25:0] want = 26'h3000000;
   logic [23:0] pci;
   logic [1:0] eack = 2'b00, ereq;
   logic [2:0] gack = 3'b000, greq;
   logic [7:0] used [8] = '{8'h03, 8'h0f, 8'h00, 8'h07, 8'h00, 8'hff, 8'h7f, 8'hff};
   logic [7:0] adr [8] = '{8'h3d, 8'h69, 8'h3c, 8'h68, 8'h3b, 8'h6b, 8'h6c, 8'h6d};
   int n_mismatch = 0, samples_checked = 0;
   always #50 clk_sys = ~clk_sys;
   epiu_pin_src u_src (.clk_sys(clk_sys), .want(want), .ext_req_pin_zero(pin0),
      .ext_req_pin_one(pin1), .pin_change_inputs(pci));
   epiu_top dut (.clk_sys(clk_sys), .srst(srst), .clk_en(clk_en), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(be), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .ext_req_pin_zero(pin0), .ext_req_pin_one(pin1), .pin_change_inputs(pci),
      .global_irq_enable(gie), .ext_vector_ack(eack), .group_vector_ack(gack),
      .ext_vector_req(ereq), .group_vector_req(greq), .wake_req(wake));
   task automatic complete_run();
      $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_read <= !wr;
      avs_write <= wr;
      // only the watchdog ends a wait that never gets its answer
      do begin
         @(posedge clk_sys);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] x);
      bus(1'b0, a, 8'h00);
      check(rd, {24'h0, x});
   endtask
   function automatic logic hit(input int m, input logic old, input logic nw);
      return old != nw && (m == 1 || (m == 2 && !nw) || (m == 3 && nw));
   endfunction
   // 20000 cycles, about fifty times the roughly 400 cycles the tests need
   initial begin
      #(20000 * 100);
      n_mismatch++;
      complete_run();
   end
   initial begin
      void'($urandom(78));
      repeat (6) @(posedge clk_sys);
      srst <= 1'b0;
      be <= 4'h0;
      bus(1'b1, 8'h3d, 8'h03);
      be <= 4'h1;
      for (int i = 0; i < 8; i++) begin
         rdchk(adr[i], 8'h00);
         msk = 8'($urandom);
         bus(1'b1, adr[i], msk);
         rdchk(adr[i], msk & used[i]);
      end
      rdchk(8'h00, 8'h00);
      $display("test registers done");
      gie <= 1'b1;
      for (int p = 0; p < 2; p++) begin
         for (int m = 1; m < 4; m++) begin
            bus(1'b1, 8'h69, 8'(m << (2 * p)));
            bus(1'b1, 8'h3d, 8'(1 << p));
            bus(1'b1, 8'h3c, 8'h03);
            for (int k = 0; k < 2; k++) begin
               want[24 + p] <= k[0];
               repeat (6) @(posedge clk_sys);
               e = hit(m, !k[0], k[0]);
               check(ereq, {1'b0, e} << p);
               rdchk(8'h3c, {7'h0, e} << p);
               if (k == 0) begin
                  bus(1'b1, 8'h3c, 8'(1 << p));
               end else begin
                  eack <= 2'(1 << p);
                  @(posedge clk_sys);
                  eack <= 2'b00;
               end
               rdchk(8'h3c, 8'h00);
            end
         end
      end
      $display("test edges done");
      bus(1'b1, 8'h69, 8'h00);
      bus(1'b1, 8'h3d, 8'h01);
      want[24] <= 1'b0;
      repeat (3) @(posedge clk_sys);
      check(ereq, 1);
      check(wake, 1);
      rdchk(8'h3c, 8'h00);
      rdchk(8'h70, 8'h10);
      gie <= 1'b0;
      @(posedge clk_sys);
      check(ereq, 0);
      gie <= 1'b1;
      want[24] <= 1'b1;
      repeat (3) @(posedge clk_sys);
      check(ereq, 0);
      $display("test level done");
      for (int g = 0; g < 3; g++) begin
         msk = 8'($urandom) & 8'h7f | 8'h01;
         bus(1'b1, 8'(8'h6b + g), msk);
         bus(1'b1, 8'h68, 8'(1 << g));
         want[8 * g + 7] <= ~want[8 * g + 7];
         repeat (3) @(posedge clk_sys);
         check(greq, 0);
         want[8 * g] <= ~want[8 * g];
         repeat (3) @(posedge clk_sys);
         check(greq, 1 << g);
         rdchk(8'h3b, 8'(1 << g));
         gie <= 1'b0;
         @(posedge clk_sys);
         check(greq, 0);
         gie <= 1'b1;
         gack <= 3'(1 << g);
         @(posedge clk_sys);
         gack <= 3'b000;
         rdchk(8'h3b, 8'h00);
      end
      $display("test groups done");
      bus(1'b1, 8'h68, 8'h01);
      bus(1'b1, 8'h69, 8'h03);
      clk_en <= 1'b0;
      want[0] <= ~want[0];
      want[24] <= 1'b0;
      repeat (4) @(posedge clk_sys);
      check(wake, 1);
      want[24] <= 1'b1;
      repeat (4) @(posedge clk_sys);
      check(ereq, 0);
      clk_en <= 1'b1;
      $display("test frozen clock done");
      complete_run();
   end
endmodule
